// >>> core/lfb_exec.sv
// Execution block for the AND group, branch-if-false (plain and delayed) and the
// overflow-checked add. Assumes a byte memory that answers a read in the same cycle.
//
// Function
// - AND register form stores Rn AND Rm into Rn in one cycle.
// - AND immediate form ANDs register zero with zero-extended byte, clearing upper bits.
// - Byte form reads at base plus register zero, ANDs, writes back; three cycles.
// - Plain branch-if-false jumps when test flag is zero, else goes sequentially.
// - Plain branch-if-false takes three cycles taken, one cycle not taken.
// - Branch target is own address plus four plus the scaled displacement.
// - Displacement is sign-extended and doubled, reaching -256 to +254 bytes.
// - Delayed branch-if-false runs the slot instruction, then jumps when flag zero.
// - Delayed branch-if-false takes two cycles taken, one cycle not taken.
// - No interrupts or address errors accepted between a taken delayed branch and its slot.
// - A branch in the slot of a taken delayed branch is treated as an illegal slot instruction.
// - Overflow-checked add stores the sum and sets flag on signed overflow.
// - Illegal or branch instruction in a taken delayed branch's slot starts illegal-instruction exception.
module lfb_exec (
  input  wire logic        core_clk,        // Core clock, 10 MHz.
  input  wire logic        rst_n,           // Asynchronous reset, active low.
  input  wire logic        instr_valid,     // Instruction word offered.
  input  wire logic [15:0] instr,           // Instruction word.
  output logic             instr_ready,     // Block takes an offered word.
  input  wire logic        preset_gpr_en,   // Load a general register while idle.
  input  wire logic        preset_base_en,  // Load the global base register while idle.
  input  wire logic        preset_pc_en,    // Load the program counter while idle.
  input  wire logic        preset_t_en,     // Load the test flag while idle.
  input  wire logic [3:0]  preset_idx,      // General register index for the preset.
  input  wire logic [31:0] preset_data,     // Preset value; bit 0 for the flag.
  output logic             mem_rd,          // Byte read strobe.
  output logic             mem_wr,          // Byte write strobe.
  output logic [31:0]      mem_addr,        // Byte address.
  output logic [7:0]       mem_wdata,       // Byte write data.
  input  wire logic [7:0]  mem_rdata,       // Byte read data, valid while mem_rd.
  output logic [31:0]      program_counter, // Address of the next instruction.
  output logic             t_flag,          // Test flag.
  output logic             wb_valid,        // A general register was written.
  output logic [3:0]       wb_idx,          // Index of that register.
  output logic [31:0]      wb_data,         // Value written.
  output logic             int_block,       // Interrupts and address errors held off.
  output logic             illegal_exc      // Illegal-instruction exception request.
);

  typedef struct packed {
    lfb_pkg::lfb_state_type state;
    logic [1:0]             cnt;
    logic [15:0][31:0]      gpr;
    logic [31:0]            global_base_reg;
    logic [31:0]            program_counter;
    logic                   t_flag;
    logic                   slot_pend;
    logic [31:0]            slot_target;
    logic [7:0]             imm;
    logic                   ready;
    logic                   mem_rd;
    logic                   mem_wr;
    logic [31:0]            mem_addr;
    logic [7:0]             mem_wdata;
    logic                   wb_valid;
    logic [3:0]             wb_idx;
    logic [31:0]            wb_data;
    logic                   illegal_exc;
  } lfb_regs_type;

  localparam lfb_regs_type RESET_REGS = '{
    state: lfb_pkg::LFB_IDLE, cnt: 2'h0, gpr: '0, global_base_reg: 32'h0000_0000,
    program_counter: lfb_pkg::PC_RESET, t_flag: 1'b0, slot_pend: 1'b0,
    slot_target: 32'h0000_0000, imm: 8'h00, ready: 1'b1, mem_rd: 1'b0, mem_wr: 1'b0,
    mem_addr: 32'h0000_0000, mem_wdata: 8'h00, wb_valid: 1'b0, wb_idx: 4'h0,
    wb_data: 32'h0000_0000, illegal_exc: 1'b0};

  lfb_regs_type cur;
  lfb_regs_type next_cur;

  function automatic logic op_is(input logic [15:0] op, input logic [15:0] mask,
                                 input logic [15:0] val);
    op_is = (op & mask) == val;
  endfunction

  // Target from the branch's own address: four ahead plus the doubled signed byte.
  function automatic logic [31:0] branch_target(input logic [31:0] pc, input logic [7:0] d);
    branch_target = pc + lfb_pkg::PC_AHEAD + {{23{d[7]}}, d, 1'b0};
  endfunction

  function automatic logic is_branch(input logic [15:0] op);
    is_branch = op_is(op, lfb_pkg::M_HI8, lfb_pkg::OP_IF_FALSE)     ||
                op_is(op, lfb_pkg::M_HI8, lfb_pkg::OP_IF_FALSE_DLY) ||
                op_is(op, lfb_pkg::M_HI8, lfb_pkg::OP_BT)  ||
                op_is(op, lfb_pkg::M_HI8, lfb_pkg::OP_BTS) ||
                op_is(op, lfb_pkg::M_HI4, lfb_pkg::OP_BRA) ||
                op_is(op, lfb_pkg::M_HI4, lfb_pkg::OP_BSR) ||
                op_is(op, lfb_pkg::M_REG, lfb_pkg::OP_BRAF) ||
                op_is(op, lfb_pkg::M_REG, lfb_pkg::OP_BSRF) ||
                op_is(op, lfb_pkg::M_REG, lfb_pkg::OP_JMP) ||
                op_is(op, lfb_pkg::M_REG, lfb_pkg::OP_JSR) ||
                op_is(op, lfb_pkg::M_ALL, lfb_pkg::OP_RTS) ||
                op_is(op, lfb_pkg::M_ALL, lfb_pkg::OP_RTE);
  endfunction

  logic        accept;
  logic [3:0]  rn;
  logic [3:0]  rm;
  logic [31:0] sum;
  logic        overflow;
  logic [31:0] acc_target;

  assign accept     = instr_valid && cur.ready;
  assign rn         = instr[lfb_pkg::RN_HI:lfb_pkg::RN_LO];
  assign rm         = instr[lfb_pkg::RM_HI:lfb_pkg::RM_LO];
  assign sum        = cur.gpr[rn] + cur.gpr[rm];
  // Signed overflow: equal operand signs and a result sign that differs.
  assign overflow   = (cur.gpr[rn][31] == cur.gpr[rm][31]) && (sum[31] != cur.gpr[rn][31]);
  assign acc_target = branch_target(cur.program_counter, instr[7:0]);

  always_comb begin
    next_cur             = cur;
    next_cur.wb_valid    = 1'b0;
    next_cur.illegal_exc = 1'b0;
    next_cur.mem_rd      = 1'b0;
    next_cur.mem_wr      = 1'b0;
    case (cur.state)
      lfb_pkg::LFB_IDLE: begin
        if (accept) begin
          next_cur.slot_pend = 1'b0;
          // A slot instruction completes the delayed jump instead of stepping on.
          next_cur.program_counter = cur.slot_pend ? cur.slot_target
                                     : cur.program_counter + lfb_pkg::INSN_STEP;
          if (cur.slot_pend && (is_branch(instr) || instr == lfb_pkg::OP_ILLEGAL)) begin
            next_cur.program_counter = cur.program_counter;
            next_cur.illegal_exc     = 1'b1;
          end else if (instr == lfb_pkg::OP_ILLEGAL) begin
            next_cur.program_counter = cur.program_counter;
            next_cur.illegal_exc     = 1'b1;
          end else if (op_is(instr, lfb_pkg::M_RR, lfb_pkg::OP_AND_REG)) begin
            next_cur.gpr[rn]  = cur.gpr[rn] & cur.gpr[rm];
            next_cur.wb_valid = 1'b1;
            next_cur.wb_idx   = rn;
            next_cur.wb_data  = cur.gpr[rn] & cur.gpr[rm];
          end else if (op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_AND_IMM)) begin
            next_cur.gpr[0]   = cur.gpr[0] & {lfb_pkg::UPPER_ZERO, instr[7:0]};
            next_cur.wb_valid = 1'b1;
            next_cur.wb_idx   = 4'h0;
            next_cur.wb_data  = cur.gpr[0] & {lfb_pkg::UPPER_ZERO, instr[7:0]};
          end else if (op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_AND_BYTE)) begin
            next_cur.mem_rd   = 1'b1;
            next_cur.mem_addr = cur.global_base_reg + cur.gpr[0];
            next_cur.imm      = instr[7:0];
            next_cur.ready    = 1'b0;
            next_cur.state    = lfb_pkg::LFB_RD;
          end else if (op_is(instr, lfb_pkg::M_RR, lfb_pkg::OP_ADD_OVF)) begin
            next_cur.gpr[rn]  = sum;
            next_cur.t_flag   = overflow;
            next_cur.wb_valid = 1'b1;
            next_cur.wb_idx   = rn;
            next_cur.wb_data  = sum;
          end else if (op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_IF_FALSE) && !cur.t_flag) begin
            next_cur.program_counter = acc_target;
            next_cur.cnt             = lfb_pkg::FALSE_TAKEN_WAIT;
            next_cur.ready           = 1'b0;
            next_cur.state           = lfb_pkg::LFB_WAIT;
          end else if (op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_IF_FALSE_DLY) && !cur.t_flag) begin
            // The target is fixed now, so a slot that rewrites registers cannot move it.
            next_cur.slot_pend   = 1'b1;
            next_cur.slot_target = acc_target;
            next_cur.cnt         = lfb_pkg::DLY_TAKEN_WAIT;
            next_cur.ready       = 1'b0;
            next_cur.state       = lfb_pkg::LFB_WAIT;
          end
        end else begin
          if (preset_gpr_en) begin
            next_cur.gpr[preset_idx] = preset_data;
          end
          if (preset_base_en) begin
            next_cur.global_base_reg = preset_data;
          end
          if (preset_pc_en) begin
            next_cur.program_counter = preset_data;
          end
          if (preset_t_en) begin
            next_cur.t_flag = preset_data[0];
          end
        end
      end
      lfb_pkg::LFB_RD: begin
        next_cur.mem_wr    = 1'b1;
        next_cur.mem_wdata = mem_rdata & cur.imm;
        next_cur.state     = lfb_pkg::LFB_WR;
      end
      lfb_pkg::LFB_WR: begin
        next_cur.ready = 1'b1;
        next_cur.state = lfb_pkg::LFB_IDLE;
      end
      lfb_pkg::LFB_WAIT: begin
        next_cur.cnt = cur.cnt - 2'h1;
        if (cur.cnt == 2'h1) begin
          next_cur.ready = 1'b1;
          next_cur.state = lfb_pkg::LFB_IDLE;
        end
      end
      default: begin
        next_cur = RESET_REGS;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= RESET_REGS;
    end else begin
      cur <= next_cur;
    end
  end

  assign instr_ready     = cur.ready;
  assign mem_rd          = cur.mem_rd;
  assign mem_wr          = cur.mem_wr;
  assign mem_addr        = cur.mem_addr;
  assign mem_wdata       = cur.mem_wdata;
  assign program_counter = cur.program_counter;
  assign t_flag          = cur.t_flag;
  assign wb_valid        = cur.wb_valid;
  assign wb_idx          = cur.wb_idx;
  assign wb_data         = cur.wb_data;
  assign int_block       = cur.slot_pend;
  assign illegal_exc     = cur.illegal_exc;

  logic is_andr;
  logic is_andi;
  logic is_andb;
  logic plain;
  assign is_andr = op_is(instr, lfb_pkg::M_RR, lfb_pkg::OP_AND_REG);
  assign is_andi = op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_AND_IMM);
  assign is_andb = op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_AND_BYTE);
  assign plain   = accept && !cur.slot_pend;

  a_and_reg_result: assert property (@(posedge core_clk) disable iff (!rst_n)
    plain && is_andr |=> wb_valid && instr_ready
      && wb_data == ($past(cur.gpr[rn]) & $past(cur.gpr[rm])))
    else $error("register AND result or timing wrong");
  a_and_imm_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    plain && is_andi |=> cur.gpr[0][31:8] == lfb_pkg::UPPER_ZERO
      && cur.gpr[0][7:0] == ($past(cur.gpr[0][7:0]) & $past(instr[7:0])))
    else $error("immediate AND did not clear upper bits");
  a_and_byte_seq: assert property (@(posedge core_clk) disable iff (!rst_n)
    plain && is_andb |=> mem_rd && !instr_ready
      && mem_addr == $past(cur.global_base_reg) + $past(cur.gpr[0])
      ##1 mem_wr && mem_wdata == ($past(mem_rdata) & cur.imm) ##1 instr_ready)
    else $error("byte AND sequence wrong");
  a_false_taken_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
    plain && op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_IF_FALSE) && !t_flag
      |=> program_counter == $past(acc_target) && !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("taken branch target or three-cycle timing wrong");
  a_false_untaken: assert property (@(posedge core_clk) disable iff (!rst_n)
    plain && op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_IF_FALSE) && t_flag
      |=> instr_ready && program_counter == $past(program_counter) + lfb_pkg::INSN_STEP)
    else $error("untaken branch not one cycle");
  a_delayed_slot_timing: assert property (@(posedge core_clk) disable iff (!rst_n)
    plain && op_is(instr, lfb_pkg::M_HI8, lfb_pkg::OP_IF_FALSE_DLY) && !t_flag
      |=> !instr_ready && int_block ##1 instr_ready && int_block)
    else $error("delayed branch timing or interrupt hold wrong");
  a_slot_then_target: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && cur.slot_pend && !is_branch(instr) && instr != lfb_pkg::OP_ILLEGAL
      |=> program_counter == $past(cur.slot_target) && !int_block)
    else $error("delayed branch did not reach target after slot");
  a_slot_branch_exc: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && cur.slot_pend && is_branch(instr) |=> illegal_exc && !int_block)
    else $error("branch in slot not flagged illegal");
  a_ovf_add_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    plain && op_is(instr, lfb_pkg::M_RR, lfb_pkg::OP_ADD_OVF)
      |=> t_flag == $past(overflow) && wb_data == $past(sum))
    else $error("overflow add flag or sum wrong");
  a_and_keeps_t: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept && (is_andr || is_andi || is_andb) |=> $stable(t_flag))
    else $error("AND changed the test flag");

endmodule // lfb_exec

// >>> common/lfb_pkg.sv
// Package for the logical AND and branch-if-false execution block.
// Assumes one 10 MHz core clock and 16-bit instruction words.
package lfb_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  // Program counter arithmetic.
  localparam logic [31:0] PC_RESET  = 32'h0000_0000;
  localparam logic [31:0] INSN_STEP = 32'h0000_0002;
  localparam logic [31:0] PC_AHEAD  = 32'h0000_0004;

  // Extra cycles with the block busy after a taken branch.
  localparam logic [1:0] FALSE_TAKEN_WAIT = 2'h2;
  localparam logic [1:0] DLY_TAKEN_WAIT   = 2'h1;

  // Opcode fields.
  localparam int unsigned RN_HI = 11;
  localparam int unsigned RN_LO = 8;
  localparam int unsigned RM_HI = 7;
  localparam int unsigned RM_LO = 4;
  localparam logic [23:0] UPPER_ZERO = 24'h00_0000;

  // Match masks and values.
  localparam logic [15:0] M_RR   = 16'hF00F;
  localparam logic [15:0] M_HI8  = 16'hFF00;
  localparam logic [15:0] M_HI4  = 16'hF000;
  localparam logic [15:0] M_REG  = 16'hF0FF;
  localparam logic [15:0] M_ALL  = 16'hFFFF;
  localparam logic [15:0] OP_AND_REG   = 16'h2009;
  localparam logic [15:0] OP_AND_IMM   = 16'hC900;
  localparam logic [15:0] OP_AND_BYTE  = 16'hCD00;
  localparam logic [15:0] OP_ADD_OVF   = 16'h300F;
  localparam logic [15:0] OP_IF_FALSE  = 16'h8B00;
  localparam logic [15:0] OP_IF_FALSE_DLY = 16'h8F00;
  localparam logic [15:0] OP_BT        = 16'h8900;
  localparam logic [15:0] OP_BTS       = 16'h8D00;
  localparam logic [15:0] OP_BRA       = 16'hA000;
  localparam logic [15:0] OP_BSR       = 16'hB000;
  localparam logic [15:0] OP_BRAF      = 16'h0023;
  localparam logic [15:0] OP_BSRF      = 16'h0003;
  localparam logic [15:0] OP_JMP       = 16'h402B;
  localparam logic [15:0] OP_JSR       = 16'h400B;
  localparam logic [15:0] OP_RTS       = 16'h000B;
  localparam logic [15:0] OP_RTE       = 16'h002B;
  localparam logic [15:0] OP_ILLEGAL   = 16'hFFFF;

  typedef enum logic [3:0] {
    LFB_IDLE = 4'h1,
    LFB_RD   = 4'h2,
    LFB_WR   = 4'h4,
    LFB_WAIT = 4'h8
  } lfb_state_type;

endpackage

// >>> test/tb.sv
// Self-checking testbench for the AND group and branch-if-false execution block.
// Assumes the block answers on the cycle after a word is taken, and that memory
// reads are answered in the same cycle as the read strobe.
module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk      = 1'b0;
  logic        rst_n         = 1'b0;
  logic        instr_valid   = 1'b0;
  logic [15:0] instr         = 16'h0000;
  logic        preset_gpr_en = 1'b0;
  logic        preset_base_en = 1'b0;
  logic        preset_pc_en  = 1'b0;
  logic        preset_t_en   = 1'b0;
  logic [3:0]  preset_idx    = 4'h0;
  logic [31:0] preset_data   = 32'h0000_0000;
  logic [7:0]  mem_byte      = 8'hA5;
  logic [7:0]  mem_rdata;
  logic        instr_ready, mem_rd, mem_wr, t_flag, wb_valid, int_block, illegal_exc;
  logic [31:0] mem_addr, program_counter, wb_data;
  logic [7:0]  mem_wdata;
  logic [3:0]  wb_idx;
  int          errors      = 0;
  int          check_count = 0;

  // Outside a read the data lines carry the inverse, so a late sample cannot match.
  assign mem_rdata = mem_rd ? mem_byte : ~mem_byte;

  always #(lfb_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  lfb_exec u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .preset_gpr_en(preset_gpr_en), .preset_base_en(preset_base_en),
    .preset_pc_en(preset_pc_en), .preset_t_en(preset_t_en), .preset_idx(preset_idx),
    .preset_data(preset_data), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .program_counter(program_counter),
    .t_flag(t_flag), .wb_valid(wb_valid), .wb_idx(wb_idx), .wb_data(wb_data),
    .int_block(int_block), .illegal_exc(illegal_exc)
  );

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Kind 0 loads a general register, 1 the base register, 2 the counter, 3 the flag.
  // Each driving task lets an edge pass first, so no signal is driven twice in one step.
  task automatic preset(input int k, input logic [3:0] idx, input logic [31:0] d);
    tick();
    preset_idx    = idx;
    preset_data   = d;
    preset_gpr_en = (k == 0);
    preset_base_en = (k == 1);
    preset_pc_en  = (k == 2);
    preset_t_en   = (k == 3);
    tick();
    {preset_gpr_en, preset_base_en, preset_pc_en, preset_t_en} = 4'h0;
  endtask

  // Returns in the cycle after the word was taken, with the answer settled.
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    tick();
    instr_valid = 1'b1;
    instr = w;
    while (instr_ready !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    chk_bit("word taken", 1'b1, instr_ready);
    tick();
    instr_valid = 1'b0;
    instr = 16'h0000;
  endtask

  task automatic wait_ready(output int n);
    n = 0;
    while (instr_ready === 1'b0 && n < 10) begin
      tick();
      n++;
    end
  endtask

  task automatic test_reset;
    chk_word("pc after reset", lfb_pkg::PC_RESET, program_counter);
    chk_bit("ready after reset", 1'b1, instr_ready);
    chk_bit("flag after reset", 1'b0, t_flag);
    $display("test reset done");
  endtask

  task automatic test_and_forms;
    int n;
    preset(3, 4'h0, 32'h1);
    preset(0, 4'h1, 32'hAAAA_AAAA);
    preset(0, 4'h2, 32'h5555_5555);
    preset(0, 4'h0, 32'hFFFF_FFFF);
    preset(2, 4'h0, 32'h0000_0010);
    issue(16'h2129);
    chk_bit("and reg wb", 1'b1, wb_valid);
    chk_word("and reg data", 32'h0, wb_data);
    chk_word("and reg idx", 32'h1, {28'h0, wb_idx});
    chk_word("and reg pc", 32'h0000_0012, program_counter);
    chk_bit("and reg readiness", 1'b1, instr_ready);
    issue(16'hC90F);
    chk_word("and imm data", 32'h0000_000F, wb_data);
    chk_word("and imm idx", 32'h0, {28'h0, wb_idx});
    chk_bit("and imm flag", 1'b1, t_flag);
    preset(1, 4'h0, 32'h0000_1000);
    preset(0, 4'h0, 32'h0000_0010);
    issue(16'hCD80);
    chk_bit("and byte read", 1'b1, mem_rd);
    chk_word("and byte addr", 32'h0000_1010, mem_addr);
    tick();
    chk_bit("and byte write", 1'b1, mem_wr);
    chk_word("and byte wdata", 32'h80, {24'h0, mem_wdata});
    chk_word("and byte waddr", 32'h0000_1010, mem_addr);
    wait_ready(n);
    chk_word("and byte cycles", 32'h3, 32'(n + 2));
    chk_bit("and byte write ends", 1'b0, mem_wr);
    chk_word("and byte pc", 32'h0000_0016, program_counter);
    chk_bit("and byte flag", 1'b1, t_flag);
    $display("test and forms done");
  endtask

  task automatic test_ovf_add;
    preset(3, 4'h0, 32'h0);
    preset(0, 4'h0, 32'h0000_0002);
    preset(0, 4'h1, 32'h7FFF_FFFE);
    issue(16'h310F);
    chk_word("ovf add sum", 32'h8000_0000, wb_data);
    chk_bit("ovf add overflow", 1'b1, t_flag);
    issue(16'h310F);
    chk_word("ovf add sum 2", 32'h8000_0002, wb_data);
    chk_bit("ovf add no overflow", 1'b0, t_flag);
    $display("test ovf add done");
  endtask

  task automatic test_branch_false;
    logic [7:0]  disp [2] = '{8'h7F, 8'h80};
    logic [31:0] want [2] = '{32'h0000_0402, 32'h0000_0204};
    int n;
    for (int i = 0; i < 2; i++) begin
      preset(3, 4'h0, 32'h0);
      preset(2, 4'h0, 32'h0000_0300);
      issue({8'h8B, disp[i]});
      chk_word("false branch target", want[i], program_counter);
      wait_ready(n);
      chk_word("false branch taken cycles", 32'h3, 32'(n + 1));
    end
    preset(3, 4'h0, 32'h1);
    preset(2, 4'h0, 32'h0000_0300);
    issue(16'h8B7F);
    chk_word("false branch untaken pc", 32'h0000_0302, program_counter);
    wait_ready(n);
    chk_word("false branch untaken cycles", 32'h1, 32'(n + 1));
    $display("test branch false done");
  endtask

  task automatic test_branch_delayed;
    int n;
    preset(3, 4'h0, 32'h0);
    preset(2, 4'h0, 32'h0000_0400);
    issue(16'h8F05);
    chk_bit("delayed block", 1'b1, int_block);
    chk_word("delayed slot pc", 32'h0000_0402, program_counter);
    wait_ready(n);
    chk_word("delayed taken cycles", 32'h2, 32'(n + 1));
    chk_bit("delayed block held", 1'b1, int_block);
    issue(16'hC9FF);
    chk_bit("delayed slot runs", 1'b1, wb_valid);
    chk_word("delayed target", 32'h0000_040E, program_counter);
    chk_bit("delayed block released", 1'b0, int_block);
    preset(3, 4'h0, 32'h1);
    preset(2, 4'h0, 32'h0000_0400);
    issue(16'h8F05);
    chk_word("delayed untaken pc", 32'h0000_0402, program_counter);
    chk_bit("delayed untaken block", 1'b0, int_block);
    wait_ready(n);
    chk_word("delayed untaken cycles", 32'h1, 32'(n + 1));
    $display("test branch delayed done");
  endtask

  task automatic test_slot;
    logic [15:0] bad [13] = '{lfb_pkg::OP_IF_FALSE, lfb_pkg::OP_IF_FALSE_DLY, lfb_pkg::OP_BT,
      lfb_pkg::OP_BTS, lfb_pkg::OP_BRA, lfb_pkg::OP_BSR, lfb_pkg::OP_BRAF, lfb_pkg::OP_BSRF,
      lfb_pkg::OP_JMP, lfb_pkg::OP_JSR, lfb_pkg::OP_RTS, lfb_pkg::OP_RTE, lfb_pkg::OP_ILLEGAL};
    int n;
    foreach (bad[i]) begin
      preset(3, 4'h0, 32'h0);
      preset(2, 4'h0, 32'h0000_0500);
      issue(16'h8F02);
      wait_ready(n);
      issue(bad[i]);
      chk_bit("slot illegal", 1'b1, illegal_exc);
      chk_word("slot pc", 32'h0000_0502, program_counter);
      chk_bit("slot not run", 1'b0, wb_valid);
      chk_bit("slot block cleared", 1'b0, int_block);
    end
    preset(2, 4'h0, 32'h0000_0600);
    issue(lfb_pkg::OP_ILLEGAL);
    chk_bit("plain illegal", 1'b1, illegal_exc);
    chk_word("plain illegal pc", 32'h0000_0600, program_counter);
    $display("test slot done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    test_reset();
    test_and_forms();
    test_ovf_add();
    test_branch_false();
    test_branch_delayed();
    test_slot();
    tally_and_finish();
  end

  // The tests need a few hundred cycles; this bound only cuts a hang short.
  initial begin
    #(5000 * lfb_pkg::CLK_PERIOD_NS);
    errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    tally_and_finish();
  end
endmodule // tb
